//--- verilog/tvt_consts.vh
// Constants for the transcoder vertical blank timing block
`ifndef TVT_CONSTS_VH
`define TVT_CONSTS_VH

// Register offsets
`define TVT_OFS_VTOTAL      8'h00
`define TVT_OFS_VBLANK      8'h04
`define TVT_OFS_VRR_CTL     8'h08
`define TVT_OFS_VMIN        8'h0C
`define TVT_OFS_VMAX        8'h10
`define TVT_OFS_FLIPLINE    8'h14
`define TVT_OFS_PUSH        8'h18
`define TVT_OFS_STATUS      8'h1C
`define TVT_OFS_DATA_M      8'h20
`define TVT_OFS_DATA_N      8'h24
`define TVT_OFS_LINK_M      8'h28
`define TVT_OFS_LINK_N      8'h2C
`define TVT_OFS_LINE        8'h30

// Field positions
`define TVT_FLD_LO_MSB      15
`define TVT_FLD_HI_LSB      16
`define TVT_BIT_VRR_EN      0
`define TVT_BIT_FLIP_EN     1
`define TVT_BIT_LRR_EN      31
`define TVT_BIT_PUSH_EN     0
`define TVT_BIT_PUSH_SEND   1

// Reset values
`define TVT_RST_VTOTAL      32'h0000_0000
`define TVT_RST_VBLANK      32'h0000_0000
`define TVT_RST_ZERO        32'h0000_0000

// Timing counts
`define TVT_HLINE_CYCLES    16'h0010
`define TVT_FSTART_DELAY    16'h0002
`define TVT_LRR_STEP        16'h0004

`endif

//--- verilog/tvt_line_tick.v
// Horizontal line tick generator for the vertical timing block
`timescale 1ns/1ps
`default_nettype none

module tvt_line_tick
#(
  parameter CNT_W = 16
)
(
  // Clock and reset
  input  wire             ref_clk,
  input  wire             resetn,
  // Line length in clocks
  input  wire [CNT_W-1:0] line_len,
  // One pulse per line
  output reg              line_tick
);

  reg [CNT_W-1:0] cnt_q;

  // Count clocks, pulse at line end
  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      cnt_q     <= {CNT_W{1'b0}};
      line_tick <= 1'b0;
    end
    else if (cnt_q + {{(CNT_W-1){1'b0}}, 1'b1} >= line_len)
    begin
      cnt_q     <= {CNT_W{1'b0}};
      line_tick <= 1'b1;
    end
    else
    begin
      cnt_q     <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      line_tick <= 1'b0;
    end
  end

endmodule // tvt_line_tick

`default_nettype wire

//--- verilog/tvt_timing.v
// Transcoder vertical timing generator with variable and low refresh support
//
// Summary of operation
// - undelayed vblank rises once line count passes active end.
// - with variable refresh off, delayed vblank rises when line count reaches blank start line.
// - both vblanks fall together at wrap, once line count is at or past both total and blank end.
// - delayed vblank rising edge copies pending values into active copies.
// - frame start pulses after the update point; pixels follow it.
// - gap of blank start minus active end lines processes no pixels.
// - variable refresh stretches vblank before the gap, awaiting push.
// - link N write adopts all M/N values at next frame.
// - link and stream clocks synchronous; M/N fixed per pixel rate.
// - variable refresh varies blank between programmed minimum and maximum.
// - clearing low refresh enable steps total back gradually.
// - hardware clears push request when stretch termination begins.
`timescale 1ns/1ps
`default_nettype none
`include "tvt_consts.vh"

module tvt_timing
#(
  parameter LW    = 16,
  parameter MNW   = 24,
  parameter CNT_W = 16
)
(
  // Clock and reset
  input  wire             ref_clk,
  input  wire             resetn,
  // Register port
  input  wire [7:0]       reg_addr,
  input  wire [31:0]      reg_wdata,
  input  wire             reg_wr,
  input  wire             reg_rd,
  output reg  [31:0]      reg_rdata,
  // Vertical blank outputs to pipes
  output reg              vblank_undelayed,
  output reg              vblank_delayed,
  output reg              dbuf_update,
  output reg              frame_start,
  output reg              window2_active,
  output reg  [LW-1:0]    line_count,
  // Active M/N values
  output reg  [MNW-1:0]   data_m_active,
  output reg  [MNW-1:0]   data_n_active,
  output reg  [MNW-1:0]   link_m_active,
  output reg  [MNW-1:0]   link_n_active
);

  //--------------------------------------------------------------
  // Register storage
  //--------------------------------------------------------------
  reg [31:0]    vtotal_q;      // [15:0] active end, [31:16] total
  reg [31:0]    vblank_q;      // [15:0] blank start, [31:16] blank end
  reg [31:0]    vrr_ctl_q;
  reg [LW-1:0]  vmin_q;
  reg [LW-1:0]  vmax_q;
  reg [LW-1:0]  flipline_q;
  reg           push_en_q;
  reg           push_send_q;
  reg [MNW-1:0] data_m_q;
  reg [MNW-1:0] data_n_q;
  reg [MNW-1:0] link_m_q;
  reg [MNW-1:0] link_n_q;
  reg           mn_pend_q;
  reg [LW-1:0]  vact_act_q;
  reg [LW-1:0]  vbs_act_q;
  reg [LW-1:0]  vbe_act_q;
  reg [LW-1:0]  lrr_total_q;   // stepped total for low refresh exit
  reg           stretching_q;
  reg           term_q;
  reg [LW-1:0]  w2_left_q;
  reg [15:0]    fs_cnt_q;
  reg           fs_arm_q;
  reg           live_q;

  wire          line_tick;
  wire [LW-1:0] one = {{(LW-1){1'b0}}, 1'b1};

  wire          wr_push = reg_wr && (reg_addr == `TVT_OFS_PUSH);
  wire          vrr_en  = vrr_ctl_q[`TVT_BIT_VRR_EN];
  wire          lrr_en  = vrr_ctl_q[`TVT_BIT_LRR_EN];

  // Saturating step toward a target
  function [LW-1:0] tvt_step;
    input [LW-1:0] cur;
    input [LW-1:0] tgt;
    input [LW-1:0] stp;
    begin
      if (cur > tgt + stp)
        tvt_step = cur - stp;
      else if (cur + stp < tgt)
        tvt_step = cur + stp;
      else
        tvt_step = tgt;
    end
  endfunction

  //--------------------------------------------------------------
  // Line tick
  //--------------------------------------------------------------
  tvt_line_tick
  #(
    .CNT_W (CNT_W)
  )
  u_line_tick
  (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .line_len  (`TVT_HLINE_CYCLES),
    .line_tick (line_tick)
  );

  //--------------------------------------------------------------
  // Register writes
  //--------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      vtotal_q    <= `TVT_RST_VTOTAL;
      vblank_q    <= `TVT_RST_VBLANK;
      vrr_ctl_q   <= `TVT_RST_ZERO;
      vmin_q      <= {LW{1'b0}};
      vmax_q      <= {LW{1'b0}};
      flipline_q  <= {LW{1'b0}};
      push_en_q   <= 1'b0;
      data_m_q    <= {MNW{1'b0}};
      data_n_q    <= {MNW{1'b0}};
      link_m_q    <= {MNW{1'b0}};
      link_n_q    <= {MNW{1'b0}};
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `TVT_OFS_VTOTAL:   vtotal_q   <= reg_wdata;
        `TVT_OFS_VBLANK:   vblank_q   <= reg_wdata;
        `TVT_OFS_VRR_CTL:  vrr_ctl_q  <= reg_wdata;
        `TVT_OFS_VMIN:     vmin_q     <= reg_wdata[LW-1:0];
        `TVT_OFS_VMAX:     vmax_q     <= reg_wdata[LW-1:0];
        `TVT_OFS_FLIPLINE: flipline_q <= reg_wdata[LW-1:0];
        `TVT_OFS_PUSH:     push_en_q  <= reg_wdata[`TVT_BIT_PUSH_EN];
        `TVT_OFS_DATA_M:   data_m_q   <= reg_wdata[MNW-1:0];
        `TVT_OFS_DATA_N:   data_n_q   <= reg_wdata[MNW-1:0];
        `TVT_OFS_LINK_M:   link_m_q   <= reg_wdata[MNW-1:0];
        `TVT_OFS_LINK_N:   link_n_q   <= reg_wdata[MNW-1:0];
        default:           ;
      endcase
    end
  end

  //--------------------------------------------------------------
  // Read data, one cycle after the strobe
  //--------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (!resetn)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `TVT_OFS_VTOTAL:   reg_rdata <= vtotal_q;
        `TVT_OFS_VBLANK:   reg_rdata <= vblank_q;
        `TVT_OFS_VRR_CTL:  reg_rdata <= vrr_ctl_q;
        `TVT_OFS_VMIN:     reg_rdata <= {{(32-LW){1'b0}}, vmin_q};
        `TVT_OFS_VMAX:     reg_rdata <= {{(32-LW){1'b0}}, vmax_q};
        `TVT_OFS_FLIPLINE: reg_rdata <= {{(32-LW){1'b0}}, flipline_q};
        `TVT_OFS_PUSH:     reg_rdata <= {{30{1'b0}}, push_send_q, push_en_q};
        `TVT_OFS_STATUS:   reg_rdata <= {28'h000_0000, live_q, stretching_q,
                                         vblank_delayed, vblank_undelayed};
        `TVT_OFS_DATA_M:   reg_rdata <= {{(32-MNW){1'b0}}, data_m_active};
        `TVT_OFS_DATA_N:   reg_rdata <= {{(32-MNW){1'b0}}, data_n_active};
        `TVT_OFS_LINK_M:   reg_rdata <= {{(32-MNW){1'b0}}, link_m_active};
        `TVT_OFS_LINK_N:   reg_rdata <= {{(32-MNW){1'b0}}, link_n_active};
        `TVT_OFS_LINE:     reg_rdata <= {{(32-LW){1'b0}}, line_count};
        default:           reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

  //--------------------------------------------------------------
  // Push request: set by software, cleared at termination start
  //--------------------------------------------------------------
  // Termination waits for the minimum, so an early push is held, not lost
  wire term_start = stretching_q && line_tick && (line_count + one >= vmin_q) &&
                    ((push_send_q && (!vrr_ctl_q[`TVT_BIT_FLIP_EN] ||
                                      line_count + one >= flipline_q)) ||
                     (line_count + one >= vmax_q));

  always @(posedge ref_clk)
  begin
    if (!resetn)
      push_send_q <= 1'b0;
    else if (wr_push && reg_wdata[`TVT_BIT_PUSH_SEND] && push_en_q)
      push_send_q <= 1'b1;                   // Set wins over clear
    else if (term_start)
      push_send_q <= 1'b0;
  end

  //--------------------------------------------------------------
  // Line counter and vertical blank generation
  //--------------------------------------------------------------
  wire [LW-1:0] eff_total = lrr_total_q;
  // Frame ends only after the update point, so zero copies after reset
  // cannot lock the counter at line zero; stepped total may exceed blank end
  wire          at_wrap   = vblank_delayed && (line_count >= eff_total) &&
                            (line_count >= vbe_act_q);
  wire          in_gap    = (vbs_act_q > vact_act_q);

  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      line_count       <= {LW{1'b0}};
      vblank_undelayed <= 1'b0;
      vblank_delayed   <= 1'b0;
      stretching_q     <= 1'b0;
      term_q           <= 1'b0;
      w2_left_q        <= {LW{1'b0}};
      window2_active   <= 1'b0;
      live_q           <= 1'b0;
    end
    else if (line_tick)
    begin
      if (at_wrap && !stretching_q)
      begin
        line_count <= {LW{1'b0}};
        vblank_undelayed <= 1'b0;
        vblank_delayed   <= 1'b0;
        window2_active   <= 1'b0;
        term_q           <= 1'b0;
        live_q           <= vrr_en;
      end
      else
      begin
        line_count <= line_count + one;
        if (line_count + one > vact_act_q && !vblank_undelayed)
        begin
          vblank_undelayed <= 1'b1;
          stretching_q <= vrr_en && (line_count + one < vmax_q);
        end
        // stretch ends between min and max
        if (term_start && line_count + one >= vmin_q)
        begin
          stretching_q <= 1'b0;
          term_q       <= 1'b1;
        end
        // window 2 spans start minus end lines with variable refresh, two lines fewer without
        if (!stretching_q && vblank_undelayed && !vblank_delayed && in_gap)
          window2_active <= 1'b1;
        if (!stretching_q && !vblank_delayed &&
            ((!vrr_en && line_count + one >= vbs_act_q) ||
             (vrr_en && term_q && w2_left_q == {LW{1'b0}})))
        begin
          vblank_delayed <= 1'b1;
          window2_active <= 1'b0;
        end
        if (term_q && w2_left_q != {LW{1'b0}})
          w2_left_q <= w2_left_q - one;
        else if (!term_q)
          w2_left_q <= vbs_act_q - vact_act_q;
      end
    end
  end

  //--------------------------------------------------------------
  // Double-buffer update at delayed vblank rise, then frame start
  //--------------------------------------------------------------
  wire vbd_rise = line_tick && !vblank_delayed && !stretching_q &&
                  ((!vrr_en && line_count + one >= vbs_act_q &&
                    !(at_wrap)) ||
                   (vrr_en && term_q && w2_left_q == {LW{1'b0}}));

  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      dbuf_update  <= 1'b0;
      vact_act_q   <= {LW{1'b0}};
      vbs_act_q    <= {LW{1'b0}};
      vbe_act_q    <= {LW{1'b0}};
      lrr_total_q  <= {LW{1'b0}};
    end
    else
    begin
      dbuf_update <= vbd_rise;
      if (vbd_rise)
      begin
        vact_act_q   <= vtotal_q[`TVT_FLD_LO_MSB:0];
        vbs_act_q    <= vblank_q[`TVT_FLD_LO_MSB:0];
        vbe_act_q    <= vblank_q[31:`TVT_FLD_HI_LSB];
        // gradual step after low refresh off
        if (lrr_en || lrr_total_q == {LW{1'b0}})
          lrr_total_q <= vtotal_q[31:`TVT_FLD_HI_LSB];
        else
          lrr_total_q <= tvt_step(lrr_total_q, vtotal_q[31:`TVT_FLD_HI_LSB],
                                  `TVT_LRR_STEP);
      end
    end
  end

  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      fs_cnt_q    <= 16'h0000;
      fs_arm_q    <= 1'b0;
      frame_start <= 1'b0;
    end
    else if (dbuf_update)
    begin
      fs_cnt_q    <= `TVT_FSTART_DELAY;
      fs_arm_q    <= 1'b1;
      frame_start <= 1'b0;
    end
    else if (fs_arm_q && fs_cnt_q == 16'h0000)
    begin
      fs_arm_q    <= 1'b0;
      frame_start <= 1'b1;
    end
    else
    begin
      fs_cnt_q    <= (fs_cnt_q == 16'h0000) ? 16'h0000 : fs_cnt_q - 16'h0001;
      frame_start <= 1'b0;
    end
  end

  //--------------------------------------------------------------
  // M/N adoption: link N write arms, next frame start applies
  //--------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      mn_pend_q     <= 1'b0;
      data_m_active <= {MNW{1'b0}};
      data_n_active <= {MNW{1'b0}};
      link_m_active <= {MNW{1'b0}};
      link_n_active <= {MNW{1'b0}};
    end
    else if (mn_pend_q && frame_start)
    begin
      mn_pend_q     <= reg_wr && (reg_addr == `TVT_OFS_LINK_N);
      data_m_active <= data_m_q;
      data_n_active <= data_n_q;
      link_m_active <= link_m_q;
      link_n_active <= link_n_q;
    end
    else if (reg_wr && (reg_addr == `TVT_OFS_LINK_N))
      mn_pend_q <= 1'b1;
  end

endmodule // tvt_timing

`default_nettype wire

//--- sim/tvt_timing_chk_sva.sv
// Concurrent checks on the vertical blank timing block ports
`timescale 1ns/1ps
`default_nettype none

module tvt_timing_chk
#(
  parameter LW  = 16,
  parameter MNW = 24
)
(
  // Clock and reset
  input wire logic           ref_clk,
  input wire logic           resetn,
  // Blank and frame outputs
  input wire logic           vblank_undelayed,
  input wire logic           vblank_delayed,
  input wire logic           dbuf_update,
  input wire logic           frame_start,
  input wire logic           window2_active,
  input wire logic [LW-1:0]  line_count,
  // Active ratio value
  input wire logic [MNW-1:0] link_n_active
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // ------------------------------------------------------------
  // Update point and frame start
  // ------------------------------------------------------------
  dbuf_after_rise_a: assert property ($rose(vblank_delayed) |-> dbuf_update)
    else $error("update missing at delayed blank rise");
  dbuf_cause_a: assert property (dbuf_update |-> vblank_delayed &&
    !$past(vblank_delayed)) else $error("update without delayed blank rise");
  fstart_bound_a: assert property (dbuf_update |-> ##[1:8] frame_start)
    else $error("frame start late after update");
  mn_at_fstart_a: assert property ($changed(link_n_active) |->
    frame_start || $past(frame_start)) else $error("ratio changed away from frame start");

  // ------------------------------------------------------------
  // Blank levels and line counter
  // ------------------------------------------------------------
  fall_together_a: assert property ($fell(vblank_undelayed) == $fell(vblank_delayed))
    else $error("blank outputs fell apart");
  wrap_at_fall_a: assert property ($fell(vblank_undelayed) |-> line_count == '0)
    else $error("blank fell away from line wrap");
  line_step_a: assert property ($changed(line_count) |->
    line_count == $past(line_count) + 1'b1 || line_count == '0)
    else $error("line counter jumped");
  line_hold_a: assert property ($changed(line_count) |=> $stable(line_count) [*8])
    else $error("line counter changed within a line");
  w2_between_a: assert property (window2_active |-> vblank_undelayed && !vblank_delayed)
    else $error("gap outside the two blank edges");
endmodule // tvt_timing_chk

bind tvt_timing tvt_timing_chk #(.LW(LW), .MNW(MNW)) u_tvt_timing_chk
(
  .ref_clk          (ref_clk),
  .resetn           (resetn),
  .vblank_undelayed (vblank_undelayed),
  .vblank_delayed   (vblank_delayed),
  .dbuf_update      (dbuf_update),
  .frame_start      (frame_start),
  .window2_active   (window2_active),
  .line_count       (line_count),
  .link_n_active    (link_n_active)
);

`default_nettype wire

//--- sim/tvt_pipe_model.sv
// Pipe model that consumes the update and frame start pulses
`timescale 1ns/1ps
`default_nettype none

module tvt_pipe_model
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Pulses from the timing block
  input  wire logic       dbuf_update,
  input  wire logic       frame_start,
  // Frame count and order flag
  output logic      [7:0] fs_count,
  output logic            order_err
);
  logic armed_q;

  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      armed_q   <= 1'b0;
      fs_count  <= 8'h00;
      order_err <= 1'b0;
    end
    else
    begin
      if (dbuf_update)
        armed_q <= 1'b1;
      if (frame_start)
      begin
        armed_q  <= 1'b0;
        fs_count <= fs_count + 8'h01;
        if (!armed_q)
          order_err <= 1'b1;
      end
    end
  end
endmodule // tvt_pipe_model

`default_nettype wire

//--- sim/tvt_timing_tb.sv
// Self-checking testbench for the vertical blank timing block
`timescale 1ns/1ps
`default_nettype none

module tvt_timing_tb;
  logic        ref_clk   = 1'b0;
  logic        resetn    = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  wire  [31:0] reg_rdata;
  wire         vblank_undelayed, vblank_delayed, dbuf_update, frame_start, window2_active;
  wire  [15:0] line_count;
  wire  [23:0] data_m_active, data_n_active, link_m_active, link_n_active;
  wire  [7:0]  fs_count;
  wire         order_err;
  int          errors    = 0;
  int          n_tests   = 0;

  always #25 ref_clk = ~ref_clk;

  tvt_timing u_tvt_timing (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .vblank_undelayed(vblank_undelayed), .vblank_delayed(vblank_delayed),
    .dbuf_update(dbuf_update), .frame_start(frame_start), .window2_active(window2_active),
    .line_count(line_count), .data_m_active(data_m_active), .data_n_active(data_n_active),
    .link_m_active(link_m_active), .link_n_active(link_n_active));

  tvt_pipe_model u_tvt_pipe_model (.ref_clk(ref_clk), .resetn(resetn),
    .dbuf_update(dbuf_update), .frame_start(frame_start), .fs_count(fs_count),
    .order_err(order_err));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task results;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  function logic sel(input int w);
    case (w)
      0: return dbuf_update;
      1: return frame_start;
      2: return vblank_undelayed;
      3: return vblank_delayed;
      4: return window2_active;
      default: return line_count == 16'h0000;
    endcase
  endfunction

  // Bounded wait for a level, returns cycles spent
  task wait_for(input int w, input logic v, output int cyc);
    cyc = 0;
    while (sel(w) !== v)
    begin
      @(posedge ref_clk);
      #1 cyc++;
      if (cyc > 3000)
      begin
        errors++;
        $display("[FAIL] wait %0d expected %b seen timeout", w, v);
        results();
      end
    end
  endtask

  // Cycles from one line zero start to the next
  task frame_len(output int n);
    int c;
    wait_for(5, 1'b0, c);
    wait_for(5, 1'b1, c);
    wait_for(5, 1'b0, n);
    wait_for(5, 1'b1, c);
    n = n + c;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_fixed;
    int c;
    wr(8'h00, 32'h000A_0004);
    wr(8'h04, 32'h000A_0006);
    wait_for(0, 1'b1, c);
    wait_for(5, 1'b1, c);
    wait_for(2, 1'b1, c);
    chk("undelayed rise line", 5, line_count);
    wait_for(3, 1'b1, c);
    chk("delayed rise line", 6, line_count);
    wait_for(2, 1'b0, c);
    chk("fall line", 0, line_count);
    chk("delayed fall", 0, vblank_delayed);
    frame_len(c);
    chk("frame cycles", 11 * 16, c);
  endtask

  task t_mn;
    logic [31:0] d;
    int c;
    wr(8'h20, 32'h0000_0111);
    wr(8'h24, 32'h0000_0222);
    wr(8'h28, 32'h0000_0333);
    rd(8'h28, d);
    chk("link m before n", 0, d);
    wr(8'h2C, 32'h0000_0444);
    wait_for(1, 1'b1, c);
    repeat (2) @(posedge ref_clk);
    #1 chk("data m", 32'h0000_0111, data_m_active);
    chk("data n", 32'h0000_0222, data_n_active);
    chk("link m", 32'h0000_0333, link_m_active);
    rd(8'h2C, d);
    chk("link n read", 32'h0000_0444, d);
    rd(8'h40, d);
    chk("unmapped read", 0, d);
    wait_for(1, 1'b0, c);
    wait_for(1, 1'b1, c);
    chk("link n kept", 32'h0000_0444, link_n_active);
  endtask

  task t_vrr;
    logic [31:0] d;
    int c;
    int n;
    wr(8'h0C, 32'h0000_000C);
    wr(8'h10, 32'h0000_0014);
    wr(8'h18, 32'h0000_0001);
    wr(8'h08, 32'h0000_0001);
    repeat (2) frame_len(n);
    chk("vmax stretch", 1, n >= 320 && n <= 400);
    wait_for(4, 1'b1, c);
    wait_for(4, 1'b0, c);
    chk("gap cycles", 32, c);
    chk("delayed after gap", 1, vblank_delayed);
    wait_for(5, 1'b0, c);
    wait_for(5, 1'b1, c);
    wr(8'h18, 32'h0000_0003);
    wait_for(5, 1'b0, c);
    wait_for(5, 1'b1, n);
    chk("push frame", 1, c + n + 2 >= 192 && c + n + 2 <= 304);
    rd(8'h18, d);
    chk("push cleared", 32'h0000_0001, d);
  endtask

  task t_lrr;
    int n;
    int k;
    wr(8'h08, 32'h8000_0000);
    wr(8'h00, 32'h001E_0004);
    wr(8'h04, 32'h001E_0006);
    repeat (3) frame_len(n);
    chk("low rate frame", 31 * 16, n);
    wr(8'h00, 32'h000A_0004);
    wr(8'h04, 32'h000A_0006);
    wr(8'h08, 32'h0000_0000);
    repeat (2) frame_len(n);
    chk("gradual exit", 1, n > 176 && n < 496);
    for (k = 0; k < 8 && n != 176; k++)
      frame_len(n);
    chk("nominal reached", 176, n);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    t_fixed();
    t_mn();
    t_vrr();
    t_lrr();
    chk("pipe order", 0, order_err);
    chk("pipe frames", 1, fs_count != 8'h00);
    results();
  end
endmodule // tvt_timing_tb

`default_nettype wire
